//--- pkg/sysrst_pkg.sv
// constants for the sysref alignment and reset control block
package sysrst_pkg;
   // register byte offsets
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] DELAY_OFFSET = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;
   localparam logic [11:0] LMFC_OFFSET = 12'h00C;
   // control field positions
   localparam int CTRL_TRIGGER_BIT = 0;
   localparam int CTRL_PDN_BIT = 1;
   localparam int CTRL_DIVMASK_BIT = 2;
   localparam int CTRL_OSCMASK_BIT = 3;
   // reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [3:0] DELAY_RESET = 4'h0;
   localparam logic [7:0] LMFC_PERIOD_RESET = 8'h1F;
   localparam logic [3:0] FRAME_PERIOD_RESET = 4'h3;
   // assertion counter saturation value
   localparam logic [1:0] COUNT_SAT = 2'h3;
   // delay line depth and width
   localparam int DELAY_DEPTH = 16;
   localparam int DELAY_W = 4;
endpackage

//--- verilog/sysrst_delay.sv
// programmable delay line for the captured sysref level
`timescale 1ns/1ps
module sysrst_delay #(
   parameter int DEPTH = sysrst_pkg::DELAY_DEPTH,
   parameter int SEL_W = sysrst_pkg::DELAY_W
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic din,
   input wire logic [SEL_W-1:0] sel,
   output logic dout
);
   logic [DEPTH-1:0] tap_reg;
   logic [DEPTH-1:0] tap_next;
   logic dout_reg;
   logic dout_next;

   always_comb begin
      tap_next = {tap_reg[DEPTH-2:0], din};
      dout_next = tap_reg[sel];
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tap_reg <= '0;
         dout_reg <= 1'b0;
      end else begin
         tap_reg <= tap_next;
         dout_reg <= dout_next;
      end
   end

   assign dout = dout_reg;
endmodule // sysrst_delay

//--- verilog/sysrst_ctrl.sv
// sysref capture, assertion counting and reset pulse generation
`timescale 1ns/1ps
module sysrst_ctrl (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sysref_pin,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic divider_reset,
   output logic oscillator_reset,
   output logic filter_reset,
   output logic multiframe_reset,
   output logic frame_clock,
   output logic multiframe_clock
);
   // ----------------------------------------
   // pin synchroniser and delay
   // ----------------------------------------
   logic sync1_reg;
   logic sync2_reg;
   logic delayed;
   logic prev_reg;
   logic prev_next;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= sysref_pin;
         sync2_reg <= sync1_reg;
      end
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [3:0] ctrl_reg;
   logic [3:0] ctrl_next;
   logic [3:0] delay_reg;
   logic [3:0] delay_next;
   logic [7:0] lmfc_period_reg;
   logic [7:0] lmfc_period_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic [7:0] lmfc_cnt_reg;
   logic [7:0] lmfc_cnt_next;

   // ----------------------------------------
   // input delay line
   // ----------------------------------------

   sysrst_delay #(
      .DEPTH(sysrst_pkg::DELAY_DEPTH),
      .SEL_W(sysrst_pkg::DELAY_W)
   ) u_delay (
      .clock(clock),
      .sys_rst(sys_rst),
      .din(sync2_reg),
      .sel(delay_reg),
      .dout(delayed)
   );

   // ----------------------------------------
   // bus access decode
   // ----------------------------------------

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == sysrst_pkg::CTRL_OFFSET) ||
                (a == sysrst_pkg::DELAY_OFFSET) ||
                (a == sysrst_pkg::STATUS_OFFSET) ||
                (a == sysrst_pkg::LMFC_OFFSET);
   endfunction

   logic access;
   logic commit;
   assign access = psel && penable && !pready_reg;
   // a write lands at the edge that completes the transfer
   assign commit = psel && penable && pready_reg && pwrite;

   always_comb begin
      ctrl_next = ctrl_reg;
      delay_next = delay_reg;
      lmfc_period_next = lmfc_period_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (access) begin
         pready_next = 1'b1;
         pslverr_next = !addr_ok(paddr);
         if (!pwrite) begin
            case (paddr)
               sysrst_pkg::CTRL_OFFSET: prdata_next = {28'h0, ctrl_reg};
               sysrst_pkg::DELAY_OFFSET: prdata_next = {28'h0, delay_reg};
               sysrst_pkg::STATUS_OFFSET:
                  prdata_next = {22'h0, lmfc_cnt_reg, count_reg};
               sysrst_pkg::LMFC_OFFSET:
                  prdata_next = {24'h0, lmfc_period_reg};
               default: prdata_next = 32'h0;
            endcase
         end
      end
      if (commit) begin
         case (paddr)
            sysrst_pkg::CTRL_OFFSET: ctrl_next = pwdata[3:0];
            sysrst_pkg::DELAY_OFFSET: delay_next = pwdata[3:0];
            sysrst_pkg::LMFC_OFFSET: lmfc_period_next = pwdata[7:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_reg <= sysrst_pkg::CTRL_RESET;
         delay_reg <= sysrst_pkg::DELAY_RESET;
         lmfc_period_reg <= sysrst_pkg::LMFC_PERIOD_RESET;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         delay_reg <= delay_next;
         lmfc_period_reg <= lmfc_period_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------
   // assertion detection and counting
   // ----------------------------------------
   logic trig_prev_reg;
   logic trig_prev_next;
   logic gated;
   logic pin_edge;
   logic soft_edge;
   logic assertion;
   logic pdn;
   logic div_mask;
   logic osc_mask;

   assign pdn = ctrl_reg[sysrst_pkg::CTRL_PDN_BIT];
   assign div_mask = ctrl_reg[sysrst_pkg::CTRL_DIVMASK_BIT];
   assign osc_mask = ctrl_reg[sysrst_pkg::CTRL_OSCMASK_BIT];
   // gated buffer input forced low when powered down
   assign gated = delayed && !pdn;
   // held high while down: re-enabling on a high level is no edge
   assign prev_next = gated || pdn;
   assign pin_edge = gated && !prev_reg;
   assign soft_edge = ctrl_reg[sysrst_pkg::CTRL_TRIGGER_BIT] &&
                      !trig_prev_reg;
   // bursts and periodic waveforms handled alike
   assign assertion = pin_edge || soft_edge;

   // ----------------------------------------
   // assertion counter
   // ----------------------------------------

   logic qualify;
   assign qualify = assertion && (count_reg == sysrst_pkg::COUNT_SAT);

   always_comb begin
      count_next = count_reg;
      if (assertion && count_reg != sysrst_pkg::COUNT_SAT) begin
         count_next = count_reg + 2'h1;
      end
   end

   // ----------------------------------------
   // reset pulse generation
   // ----------------------------------------

   logic div_rst_reg;
   logic div_rst_next;
   logic osc_rst_reg;
   logic osc_rst_next;
   logic flt_rst_reg;
   logic flt_rst_next;
   logic mf_rst_reg;
   logic mf_rst_next;
   logic osc_ok;

   // third assertion counts: counter reaches sat on the third
   assign osc_ok = assertion && (count_reg == 2'h2 || qualify) &&
                   !osc_mask;

   always_comb begin
      div_rst_next = assertion && !div_mask;
      flt_rst_next = assertion;
      osc_rst_next = osc_ok;
      mf_rst_next = osc_ok;
      trig_prev_next = ctrl_reg[sysrst_pkg::CTRL_TRIGGER_BIT];
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prev_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
         count_reg <= 2'h0;
         div_rst_reg <= 1'b0;
         osc_rst_reg <= 1'b0;
         flt_rst_reg <= 1'b0;
         mf_rst_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         trig_prev_reg <= trig_prev_next;
         count_reg <= count_next;
         div_rst_reg <= div_rst_next;
         osc_rst_reg <= osc_rst_next;
         flt_rst_reg <= flt_rst_next;
         mf_rst_reg <= mf_rst_next;
      end
   end

   // ----------------------------------------
   // reset pulse outputs
   // ----------------------------------------

   assign divider_reset = div_rst_reg;
   assign oscillator_reset = osc_rst_reg;
   assign filter_reset = flt_rst_reg;
   assign multiframe_reset = mf_rst_reg;

   // ----------------------------------------
   // local frame and multiframe clocks
   // ----------------------------------------
   logic [3:0] frm_cnt_reg;
   logic [3:0] frm_cnt_next;
   logic frm_clk_reg;
   logic frm_clk_next;
   logic mf_clk_reg;
   logic mf_clk_next;

   always_comb begin
      frm_cnt_next = frm_cnt_reg + 4'h1;
      lmfc_cnt_next = lmfc_cnt_reg + 8'h01;
      if (frm_cnt_reg == sysrst_pkg::FRAME_PERIOD_RESET) begin
         frm_cnt_next = 4'h0;
      end
      if (lmfc_cnt_reg >= lmfc_period_reg) begin
         lmfc_cnt_next = 8'h00;
      end
      // realignment may repeat a clock pulse at once
      if (osc_ok) begin
         frm_cnt_next = 4'h0;
         lmfc_cnt_next = 8'h00;
      end
      frm_clk_next = (frm_cnt_next == 4'h0);
      mf_clk_next = (lmfc_cnt_next == 8'h00);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         frm_cnt_reg <= 4'h0;
         lmfc_cnt_reg <= 8'h00;
         frm_clk_reg <= 1'b0;
         mf_clk_reg <= 1'b0;
      end else begin
         frm_cnt_reg <= frm_cnt_next;
         lmfc_cnt_reg <= lmfc_cnt_next;
         frm_clk_reg <= frm_clk_next;
         mf_clk_reg <= mf_clk_next;
      end
   end

   assign frame_clock = frm_clk_reg;
   assign multiframe_clock = mf_clk_reg;
endmodule // sysrst_ctrl

//--- verif/sysrst_ctrl_sva.sv
// port assertions for the sysref reset control block
`timescale 1ns/1ps
module sysrst_ctrl_sva (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic divider_reset,
   input wire logic oscillator_reset,
   input wire logic filter_reset,
   input wire logic multiframe_reset,
   input wire logic frame_clock
);
   // ---------------------------
   // soft trigger shadow
   // ---------------------------
   logic trig_reg;
   logic trig_next;
   logic wr_ctrl;
   assign wr_ctrl = psel && penable && pready && pwrite
      && paddr == sysrst_pkg::CTRL_OFFSET;
   always_comb begin
      trig_next = wr_ctrl ? pwdata[0] : trig_reg;
   end
   always_ff @(posedge clock) begin
      trig_reg <= sys_rst ? 1'b0 : trig_next;
   end
   // ---------------------------
   // properties
   // ---------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=>
      !pready && !divider_reset && !oscillator_reset && !filter_reset)
      else $error("outputs active after reset");
   AST_WAIT_STATE: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_DIV_PULSE: assert property (
      divider_reset |=> !divider_reset) else $error("divider pulse long");
   AST_OSC_MF_EQUAL: assert property (
      oscillator_reset == multiframe_reset) else $error("osc and mf differ");
   AST_OSC_WITH_FLT: assert property (
      oscillator_reset |-> filter_reset) else $error("osc without filter");
   AST_DIV_WITH_FLT: assert property (
      divider_reset |-> filter_reset) else $error("divider without filter");
   AST_SOFT_TRIG: assert property (
      wr_ctrl && pwdata[0] && !trig_reg |-> ##2 filter_reset)
      else $error("soft trigger gave no reset");
   AST_FRAME_PULSE: assert property (
      frame_clock |=> !frame_clock || oscillator_reset)
      else $error("frame clock long");
endmodule // sysrst_ctrl_sva

bind sysrst_ctrl sysrst_ctrl_sva SVA (.clock, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .divider_reset,
   .oscillator_reset, .filter_reset, .multiframe_reset, .frame_clock);

//--- verif/sysrst_sysref_gen.sv
// model of the external sysref pulse source
`timescale 1ns/1ps
module sysrst_sysref_gen #(
   parameter int WIDTH = 3
) (
   input wire logic clock,
   input wire logic fire,
   output logic sysref_pin
);
   int hold = 0;
   initial sysref_pin = 1'b0;
   // counted pulses, held several cycles
   always @(posedge clock) begin
      if (fire) hold <= WIDTH;
      else if (hold > 0) hold <= hold - 1;
      sysref_pin <= fire || hold > 1;
   end
endmodule // sysrst_sysref_gen

//--- verif/sysrst_ctrl_test.sv
// testbench for the sysref reset control block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module sysrst_ctrl_test;
   logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic fire = 0, sysref_pin, pready, pslverr, err, frame_clock;
   logic divider_reset, oscillator_reset, filter_reset, multiframe_reset;
   logic multiframe_clock;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] dn, on, fn, mn;
   int error_cnt = 0, tests_run = 0, lat, lat0;
   localparam int SETTLE_CYC = 4001; // over 40 us of settling
   always #5 clock = ~clock;
   sysrst_sysref_gen GEN (.clock, .fire, .sysref_pin);
   sysrst_ctrl DUT (.clock, .sys_rst, .sysref_pin, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .divider_reset,
      .oscillator_reset, .filter_reset, .multiframe_reset, .frame_clock,
      .multiframe_clock);
   // ---------------------------
   // tasks
   // ---------------------------
   task results;
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin error_cnt++; results; end
   endtask
   task watch(input logic [3:0] ed, eo, ef);
      dn = 0; on = 0; fn = 0; mn = 0; lat = 0;
      repeat (40) begin
         @(posedge clock);
         if (fn == 0) lat++;
         dn += {3'h0, divider_reset};
         on += {3'h0, oscillator_reset};
         fn += {3'h0, filter_reset};
         mn += {3'h0, multiframe_reset};
         if (multiframe_reset === 1'b1) `CHK(multiframe_clock, 1'b1)
      end
      `CHK(dn, ed) `CHK(on, eo) `CHK(fn, ef)
      `CHK(mn, eo)
   endtask
   task period(input logic mf, input int ep);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while ((mf ? multiframe_clock : frame_clock) !== 1'b1
            && n < 300);
         if (n >= 300) begin error_cnt++; results; end
      end
      `CHK(n, ep)
   endtask
   task pulse(input logic [3:0] ed, eo, ef);
      @(posedge clock); fire <= 1'b1;
      @(posedge clock); fire <= 1'b0;
      watch(ed, eo, ef);
   endtask
   // ---------------------------
   // sequence
   // ---------------------------
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      apb(0, sysrst_pkg::CTRL_OFFSET, 0); `CHK(rd, 32'h0)
      apb(0, sysrst_pkg::LMFC_OFFSET, 0); `CHK(rd[7:0], 8'h1F)
      apb(0, 12'h010, 0); `CHK(err, 1'b1)
      pulse(1, 0, 1);
      repeat (SETTLE_CYC) @(posedge clock);
      pulse(1, 0, 1);
      pulse(1, 1, 1);
      pulse(1, 1, 1);
      repeat (22) @(posedge clock); pulse(1, 1, 1);
      repeat (22) @(posedge clock); pulse(1, 1, 1);
      lat0 = lat;
      apb(1, sysrst_pkg::STATUS_OFFSET, 0);
      apb(0, sysrst_pkg::STATUS_OFFSET, 0); `CHK(rd[1:0], 2'h3)
      apb(1, sysrst_pkg::DELAY_OFFSET, 5);
      pulse(1, 1, 1);
      `CHK(lat, lat0 + 5)
      apb(1, sysrst_pkg::DELAY_OFFSET, 0);
      apb(1, sysrst_pkg::CTRL_OFFSET, 4); pulse(0, 1, 1);
      apb(1, sysrst_pkg::CTRL_OFFSET, 8); pulse(1, 0, 1);
      apb(1, sysrst_pkg::CTRL_OFFSET, 2); pulse(0, 0, 0);
      apb(1, sysrst_pkg::CTRL_OFFSET, 1); watch(1, 1, 1);
      apb(1, sysrst_pkg::CTRL_OFFSET, 1); watch(0, 0, 0);
      apb(1, sysrst_pkg::CTRL_OFFSET, 0); watch(0, 0, 0);
      period(0, sysrst_pkg::FRAME_PERIOD_RESET + 1);
      period(1, sysrst_pkg::LMFC_PERIOD_RESET + 1);
      apb(1, sysrst_pkg::LMFC_OFFSET, 15); period(1, 16);
      results;
   end
endmodule // sysrst_ctrl_test
